// file: logic/cipa_pkg.sv
// cipa_pkg: constants and types of the assembly image.
// assumes one clock domain; offsets in bytes.
package cipa_pkg;
  // assembly and table sizes in bytes
  localparam logic [8:0] IN_ASM_BYTES   = 9'h1f4; // input assembly, 500
  localparam logic [8:0] IN_DATA_BYTES  = 9'h1f0; // input data area, 496
  localparam logic [8:0] OUT_DATA_BYTES = 9'h1ec; // output data area, 492
  // byte offsets
  localparam logic [8:0] STATUS_OFS   = 9'h000; // status word, input asm
  localparam logic [8:0] IN_DATA_OFS  = 9'h004; // received image start
  localparam logic [8:0] RUNIDLE_OFS  = 9'h000; // run/idle header, payload
  localparam logic [8:0] CMD_OFS      = 9'h004; // command word, payload
  localparam logic [8:0] OUT_DATA_OFS = 9'h008; // transmit image, payload
  // field positions
  localparam int unsigned ST_RUN_BIT     = 0; // status: run mode
  localparam int unsigned ST_ONLINE_BIT  = 1; // status: online
  localparam int unsigned ST_FAULT_BIT   = 2; // status: interface fault
  localparam int unsigned CMD_RUN_BIT    = 0; // command: local run
  localparam int unsigned CMD_FLTRST_BIT = 1; // command: reset faults
  localparam int unsigned CMD_MODRST_BIT = 4; // command: module reset
  localparam int unsigned RI_RUN_BIT     = 0; // header: system run
  // assembly class, instances and connection points
  localparam logic [7:0] INST_INPUT   = 8'h64; // 100
  localparam logic [7:0] INST_STATUS  = 8'h65; // 101
  localparam logic [7:0] INST_OUTPUT  = 8'h96; // 150
  localparam logic [7:0] PT_HB_INONLY = 8'hc6; // 198
  localparam logic [7:0] PT_HB_LISTEN = 8'hc7; // 199
  localparam logic [7:0] CLASS_ASSEMBLY = 8'h04; // assembly object class
  // class 1 connection sizes
  localparam logic [8:0] IN_CONN_MIN  = 9'h004;
  localparam logic [8:0] IN_CONN_MAX  = 9'h1f4;
  localparam logic [8:0] OUT_CONN_MIN = 9'h008;
  localparam logic [8:0] OUT_CONN_MAX = 9'h1f4;
  localparam logic [8:0] STAT_CONN    = 9'h00c;
  localparam logic [8:0] HB_CONN      = 9'h000;
  // concurrency limits
  localparam logic [6:0] MAX_UCMM = 7'h40; // unconnected transactions
  localparam logic [4:0] MAX_CLS3 = 5'h10; // class 3 connections
  // logical path segment types, 8-bit forms
  localparam logic [7:0] SEG_CLASS8 = 8'h20;
  localparam logic [7:0] SEG_INST8  = 8'h24;
  localparam logic [7:0] SEG_ATTR8  = 8'h30;
  // reset values and counter limit
  localparam logic [31:0] CMD_RST     = 32'h0000_0000;
  localparam logic [31:0] RUNIDLE_RST = 32'h0000_0000;
  localparam logic [15:0] CNT_MAX     = 16'hffff;
  // request parser states
  typedef enum logic [1:0] {
    PS_IDLE  = 2'b00,
    PS_PSIZE = 2'b01,
    PS_PATH  = 2'b10,
    PS_DATA  = 2'b11
  } cipa_pstate_type;
endpackage : cipa_pkg

// file: logic/cipa_req_parse.sv
// cipa_req_parse: splits explicit requests into fields.
// assumes req_first_i marks each service code byte.
`timescale 1ns/1ps
`default_nettype none
module cipa_req_parse (
  input  wire logic       ref_clk_i,   // system clock
  input  wire logic       resetn_i,    // sync reset, active low
  input  wire logic       req_valid_i, // request byte present
  input  wire logic       req_first_i, // byte is the service code
  input  wire logic [7:0] req_byte_i,  // request byte
  output logic            hdr_valid_o, // path fully decoded, pulse
  output logic      [7:0] svc_o,       // service code
  output logic      [7:0] class_o,     // class from path
  output logic      [7:0] inst_o,      // instance from path
  output logic      [7:0] attr_o,      // attribute from path
  output logic            data_valid_o,// service data byte, pulse
  output logic      [7:0] data_o,      // service data byte
  output logic            path_err_o   // unknown segment, held through hdr_valid_o
);
  typedef struct packed {
    cipa_pkg::cipa_pstate_type st; // parse position
    logic [8:0] left;              // path bytes still to come
    logic       pend;              // segment type byte held
    logic [7:0] seg;               // held segment type
    logic [7:0] svc;
    logic [7:0] cls;
    logic [7:0] ins;
    logic [7:0] att;
    logic       hdr_v;
    logic       dv;
    logic [7:0] dat;
    logic       perr;
  } cipa_parse_type;

  cipa_parse_type s_ff;  // registered state
  cipa_parse_type nxt_s; // next state

  // field order: service, path size, path segments, then data
  always_comb begin
    nxt_s       = s_ff;
    nxt_s.hdr_v = 1'b0;
    nxt_s.dv    = 1'b0;
    // a bad segment early in the path must survive to path end
    nxt_s.perr  = s_ff.perr & (s_ff.st == cipa_pkg::PS_PATH);
    if (req_valid_i && req_first_i) begin
      // a new request restarts parsing
      nxt_s.svc  = req_byte_i;
      nxt_s.perr = 1'b0;
      nxt_s.st   = cipa_pkg::PS_PSIZE;
      nxt_s.cls  = 8'h00;
      nxt_s.ins  = 8'h00;
      nxt_s.att  = 8'h00;
      nxt_s.pend = 1'b0;
    end else if (req_valid_i) begin
      case (s_ff.st)
        cipa_pkg::PS_PSIZE: begin
          // size counts 16-bit words of path
          nxt_s.left = {req_byte_i, 1'b0};
          if (req_byte_i == 8'h00) begin
            nxt_s.hdr_v = 1'b1;
            nxt_s.st    = cipa_pkg::PS_DATA;
          end else begin
            nxt_s.st = cipa_pkg::PS_PATH;
          end
        end
        cipa_pkg::PS_PATH: begin
          if (!s_ff.pend) begin
            // type byte of a segment
            nxt_s.seg  = req_byte_i;
            nxt_s.pend = 1'b1;
          end else begin
            // value byte of a segment
            nxt_s.pend = 1'b0;
            case (s_ff.seg)
              cipa_pkg::SEG_CLASS8: nxt_s.cls = req_byte_i;
              cipa_pkg::SEG_INST8:  nxt_s.ins = req_byte_i;
              cipa_pkg::SEG_ATTR8:  nxt_s.att = req_byte_i;
              default:              nxt_s.perr = 1'b1;
            endcase
          end
          nxt_s.left = s_ff.left - 9'h001;
          if (s_ff.left == 9'h001) begin
            // dangling type byte is malformed
            nxt_s.perr  = nxt_s.perr | ~s_ff.pend;
            nxt_s.hdr_v = 1'b1;
            nxt_s.st    = cipa_pkg::PS_DATA;
          end
        end
        cipa_pkg::PS_DATA: begin
          // service data after path
          nxt_s.dv  = 1'b1;
          nxt_s.dat = req_byte_i;
        end
        default: begin
          // idle: bytes before a service code are dropped
          nxt_s.st = cipa_pkg::PS_IDLE;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign hdr_valid_o  = s_ff.hdr_v;
  assign svc_o        = s_ff.svc;
  assign class_o      = s_ff.cls;
  assign inst_o       = s_ff.ins;
  assign attr_o       = s_ff.att;
  assign data_valid_o = s_ff.dv;
  assign data_o       = s_ff.dat;
  assign path_err_o   = s_ff.perr;
endmodule : cipa_req_parse
`default_nettype wire

// file: logic/cipa_io_assembly.sv
// cipa_io_assembly: input/output assembly image of the adapter.
// assumes all neighbours run on ref_clk_i; no pins.
`timescale 1ns/1ps
`default_nettype none
module cipa_io_assembly (
  input  wire logic        ref_clk_i,      // system clock, 125 MHz
  input  wire logic        resetn_i,       // sync reset, active low
  input  wire logic  [8:0] in_tbl_len_i,   // configured input length
  input  wire logic  [8:0] out_tbl_len_i,  // configured output length
  // scanner reads the input assembly
  input  wire logic        in_rd_i,        // read strobe
  input  wire logic  [8:0] in_addr_i,      // input assembly byte
  output logic       [7:0] in_rdata_o,     // read byte
  output logic             in_rvalid_o,    // read answer, pulse
  // scanner writes the output connection payload
  input  wire logic        out_wr_i,       // write strobe
  input  wire logic  [8:0] out_addr_i,     // payload byte
  input  wire logic  [7:0] out_wdata_i,    // payload data
  input  wire logic        out_done_i,     // frame complete, pulse
  // class 1 connection open request
  input  wire logic        conn_req_i,     // open strobe
  input  wire logic  [7:0] conn_o2t_pt_i,  // output connection point
  input  wire logic  [8:0] conn_o2t_sz_i,  // output size
  input  wire logic  [7:0] conn_t2o_pt_i,  // input connection point
  input  wire logic  [8:0] conn_t2o_sz_i,  // input size
  output logic             conn_ok_o,      // accepted, pulse
  output logic             conn_bad_o,     // rejected, pulse
  // unconnected and class 3 bookkeeping
  input  wire logic        ucmm_start_i,   // transaction begins
  input  wire logic        ucmm_done_i,    // transaction ends
  input  wire logic        cls3_open_i,    // class 3 opens
  input  wire logic        cls3_close_i,   // class 3 closes
  output logic             ucmm_full_o,    // no unconnected slot
  output logic             cls3_full_o,    // no class 3 slot
  output logic             refuse_o,       // start refused, pulse
  // explicit request stream
  input  wire logic        req_valid_i,    // request byte present
  input  wire logic        req_first_i,    // service code byte
  input  wire logic  [7:0] req_byte_i,     // request byte
  output logic             expl_hit_o,     // path is an assembly
  output logic             expl_miss_o,    // path not served
  output logic       [7:0] expl_svc_o,     // parsed service
  output logic       [7:0] expl_attr_o,    // parsed attribute
  // vehicle bus side
  input  wire logic        fb_rx_wr_i,     // received byte strobe
  input  wire logic  [8:0] fb_rx_addr_i,   // received image byte
  input  wire logic  [7:0] fb_rx_data_i,   // received data
  input  wire logic        fb_tx_rd_i,     // transmit image read
  input  wire logic  [8:0] fb_tx_addr_i,   // transmit image byte
  output logic       [7:0] fb_tx_data_o,   // transmit byte
  input  wire logic        online_i,       // online on vehicle net
  input  wire logic  [6:0] fault_set_i,    // fault events
  input  wire logic        err_evt_i,      // bus error event
  input  wire logic        busoff_evt_i,   // bus-off event
  input  wire logic        ovr_evt_i,      // receive overrun event
  output logic       [6:0] fault_o,        // latched faults
  output logic      [15:0] err_cnt_o,      // bus error count
  output logic      [15:0] busoff_cnt_o,   // bus-off count
  output logic      [15:0] ovr_cnt_o,      // overrun count
  output logic             run_o,          // run mode
  output logic      [31:0] cmd_o,          // committed command word
  output logic             module_rst_o    // module reset, pulse
);
  typedef struct packed {
    logic [31:0] cmd_sh;  // command bytes of frame in progress
    logic [31:0] ri_sh;   // header bytes of frame in progress
    logic [31:0] cmd;     // committed command
    logic [31:0] ri;      // committed run/idle header
    logic        run;
    logic        online;
    logic [6:0]  fault;
    logic [15:0] err_cnt;
    logic [15:0] bo_cnt;
    logic [15:0] ovr_cnt;
    logic [7:0]  rdata;
    logic        rvalid;
    logic [7:0]  txdata;
    logic        c_ok;
    logic        c_bad;
    logic [6:0]  ucmm;
    logic [4:0]  cls3;
    logic        refuse;
    logic        mod_rst;
    logic        hit;
    logic        miss;
  } cipa_state_type;

  cipa_state_type s_ff;  // registered state
  cipa_state_type nxt_s; // next state

  logic [7:0] in_mem  [0:495]; // received image, 496 bytes
  logic [7:0] out_mem [0:491]; // transmit image, 492 bytes

  logic       p_hdr;  // parser outputs
  logic [7:0] p_svc;
  logic [7:0] p_cls;
  logic [7:0] p_ins;
  logic [7:0] p_att;
  logic       p_err;

  logic [31:0] status;  // live status word
  logic [8:0]  in_idx;  // input image index
  logic [8:0]  out_idx; // output image index
  logic        fclr;    // fault reset edge at commit
  logic        mrst;    // module reset edge at commit

  // inside length and area
  function automatic logic in_tbl(input logic [8:0] idx,
                                  input logic [8:0] len,
                                  input logic [8:0] area);
    in_tbl = (idx < len) && (idx < area);
  endfunction : in_tbl

  // size inside an inclusive range
  function automatic logic sz_ok(input logic [8:0] sz,
                                 input logic [8:0] lo,
                                 input logic [8:0] hi);
    sz_ok = (sz >= lo) && (sz <= hi);
  endfunction : sz_ok

  // saturating counter, set beats clear
  function automatic logic [15:0] cnt_upd(input logic [15:0] c,
                                          input logic        clr,
                                          input logic        evt);
    if (clr) begin
      cnt_upd = {15'h0000, evt}; // set wins over clear
    end else if (evt && (c != cipa_pkg::CNT_MAX)) begin
      cnt_upd = c + 16'h0001;
    end else begin
      cnt_upd = c;
    end
  endfunction : cnt_upd

  // explicit request path decoder
  cipa_req_parse u_parse (
    .ref_clk_i    (ref_clk_i),
    .resetn_i     (resetn_i),
    .req_valid_i  (req_valid_i),
    .req_first_i  (req_first_i),
    .req_byte_i   (req_byte_i),
    .hdr_valid_o  (p_hdr),
    .svc_o        (p_svc),
    .class_o      (p_cls),
    .inst_o       (p_ins),
    .attr_o       (p_att),
    .data_valid_o (),
    .data_o       (),
    .path_err_o   (p_err)
  );

  // status word, unused bits zero
  always_comb begin
    status                = 32'h0000_0000;
    status[cipa_pkg::ST_RUN_BIT]    = s_ff.run;
    status[cipa_pkg::ST_ONLINE_BIT] = s_ff.online;
    status[cipa_pkg::ST_FAULT_BIT]  = |s_ff.fault;
  end

  assign in_idx  = in_addr_i - cipa_pkg::IN_DATA_OFS;
  assign out_idx = out_addr_i - cipa_pkg::OUT_DATA_OFS;
  // resets act on a rising bit
  assign fclr = out_done_i & s_ff.cmd_sh[cipa_pkg::CMD_FLTRST_BIT]
              & ~s_ff.cmd[cipa_pkg::CMD_FLTRST_BIT];
  assign mrst = out_done_i & s_ff.cmd_sh[cipa_pkg::CMD_MODRST_BIT]
              & ~s_ff.cmd[cipa_pkg::CMD_MODRST_BIT];

  // next-state logic
  always_comb begin
    nxt_s         = s_ff;
    nxt_s.rvalid  = 1'b0;
    nxt_s.c_ok    = 1'b0;
    nxt_s.c_bad   = 1'b0;
    nxt_s.refuse  = 1'b0;
    nxt_s.mod_rst = mrst; // bits 2, 3, 5..31 do nothing
    nxt_s.hit     = 1'b0;
    nxt_s.miss    = 1'b0;
    nxt_s.online  = online_i;
    // input read, only on request
    if (in_rd_i) begin
      nxt_s.rvalid = 1'b1;
      if (in_addr_i < cipa_pkg::IN_DATA_OFS) begin
        nxt_s.rdata = status[8*in_addr_i[1:0] +: 8];
      end else if (in_tbl(in_idx, in_tbl_len_i,
                          cipa_pkg::IN_DATA_BYTES)) begin
        nxt_s.rdata = in_mem[in_idx];
      end else begin
        nxt_s.rdata = 8'h00; // pad
      end
    end
    // payload write
    if (out_wr_i) begin
      if (out_addr_i < cipa_pkg::CMD_OFS) begin
        nxt_s.ri_sh[8*out_addr_i[1:0] +: 8] = out_wdata_i;
      end else if (out_addr_i < cipa_pkg::OUT_DATA_OFS) begin
        nxt_s.cmd_sh[8*out_addr_i[1:0] +: 8] = out_wdata_i;
      end
    end
    // frame end commits header and command together
    if (out_done_i) begin
      nxt_s.cmd = s_ff.cmd_sh;
      nxt_s.ri  = s_ff.ri_sh; // header is the scanner's alone
    end
    // run only with both run bits set
    nxt_s.run = nxt_s.cmd[cipa_pkg::CMD_RUN_BIT]
              & nxt_s.ri[cipa_pkg::RI_RUN_BIT];
    // latched faults, set beats clear
    nxt_s.fault = (fclr ? 7'h00 : s_ff.fault) | fault_set_i;
    nxt_s.err_cnt = cnt_upd(s_ff.err_cnt, fclr, err_evt_i);
    nxt_s.bo_cnt  = cnt_upd(s_ff.bo_cnt, fclr, busoff_evt_i);
    nxt_s.ovr_cnt = cnt_upd(s_ff.ovr_cnt, fclr, ovr_evt_i);
    // transmit image read
    if (fb_tx_rd_i) begin
      if (in_tbl(fb_tx_addr_i, out_tbl_len_i,
                 cipa_pkg::OUT_DATA_BYTES)) begin
        nxt_s.txdata = out_mem[fb_tx_addr_i];
      end else begin
        nxt_s.txdata = 8'h00; // outside configured length
      end
    end
    // class 1 open
    if (conn_req_i) begin
      if (((conn_t2o_pt_i == cipa_pkg::INST_INPUT &&
            sz_ok(conn_t2o_sz_i, cipa_pkg::IN_CONN_MIN,
                  cipa_pkg::IN_CONN_MAX)) ||
           (conn_t2o_pt_i == cipa_pkg::INST_STATUS &&
            conn_t2o_sz_i == cipa_pkg::STAT_CONN)) &&
          ((conn_o2t_pt_i == cipa_pkg::INST_OUTPUT &&
            sz_ok(conn_o2t_sz_i, cipa_pkg::OUT_CONN_MIN,
                  cipa_pkg::OUT_CONN_MAX)) ||
           ((conn_o2t_pt_i == cipa_pkg::PT_HB_INONLY ||
             conn_o2t_pt_i == cipa_pkg::PT_HB_LISTEN) &&
            conn_o2t_sz_i == cipa_pkg::HB_CONN))) begin
        nxt_s.c_ok = 1'b1;
      end else begin
        nxt_s.c_bad = 1'b1;
      end
    end
    // unconnected transaction slots
    if (ucmm_start_i && (s_ff.ucmm == cipa_pkg::MAX_UCMM)) begin
      nxt_s.refuse = 1'b1;
    end
    if (ucmm_start_i && (s_ff.ucmm != cipa_pkg::MAX_UCMM) &&
        !(ucmm_done_i && s_ff.ucmm != 7'h00)) begin
      nxt_s.ucmm = s_ff.ucmm + 7'h01;
    end else if (ucmm_done_i && (s_ff.ucmm != 7'h00) &&
                 !(ucmm_start_i && s_ff.ucmm != cipa_pkg::MAX_UCMM)) begin
      nxt_s.ucmm = s_ff.ucmm - 7'h01;
    end
    // class 3 connection slots
    if (cls3_open_i && (s_ff.cls3 == cipa_pkg::MAX_CLS3)) begin
      nxt_s.refuse = 1'b1;
    end
    if (cls3_open_i && (s_ff.cls3 != cipa_pkg::MAX_CLS3) &&
        !(cls3_close_i && s_ff.cls3 != 5'h00)) begin
      nxt_s.cls3 = s_ff.cls3 + 5'h01;
    end else if (cls3_close_i && (s_ff.cls3 != 5'h00) &&
                 !(cls3_open_i && s_ff.cls3 != cipa_pkg::MAX_CLS3)) begin
      nxt_s.cls3 = s_ff.cls3 - 5'h01;
    end
    // path must name an assembly
    if (p_hdr) begin
      if (!p_err && p_cls == cipa_pkg::CLASS_ASSEMBLY &&
          (p_ins == cipa_pkg::INST_INPUT ||
           p_ins == cipa_pkg::INST_STATUS ||
           p_ins == cipa_pkg::INST_OUTPUT)) begin
        nxt_s.hit = 1'b1;
      end else begin
        nxt_s.miss = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      s_ff     <= '0;
      s_ff.cmd <= cipa_pkg::CMD_RST;
      s_ff.ri  <= cipa_pkg::RUNIDLE_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // image memories hold data only, so they carry no reset
  always_ff @(posedge ref_clk_i) begin
    if (fb_rx_wr_i && in_tbl(fb_rx_addr_i, in_tbl_len_i,
                             cipa_pkg::IN_DATA_BYTES)) begin
      in_mem[fb_rx_addr_i] <= fb_rx_data_i;
    end
    if (out_wr_i && (out_addr_i >= cipa_pkg::OUT_DATA_OFS) &&
        in_tbl(out_idx, out_tbl_len_i, cipa_pkg::OUT_DATA_BYTES)) begin
      out_mem[out_idx] <= out_wdata_i; // beyond length dropped
    end
  end

  assign in_rdata_o   = s_ff.rdata;
  assign in_rvalid_o  = s_ff.rvalid;
  assign conn_ok_o    = s_ff.c_ok;
  assign conn_bad_o   = s_ff.c_bad;
  assign ucmm_full_o  = (s_ff.ucmm == cipa_pkg::MAX_UCMM);
  assign cls3_full_o  = (s_ff.cls3 == cipa_pkg::MAX_CLS3);
  assign refuse_o     = s_ff.refuse;
  assign expl_hit_o   = s_ff.hit;
  assign expl_miss_o  = s_ff.miss;
  assign expl_svc_o   = p_svc;
  assign expl_attr_o  = p_att;
  assign fb_tx_data_o = s_ff.txdata;
  assign fault_o      = s_ff.fault;
  assign err_cnt_o    = s_ff.err_cnt;
  assign busoff_cnt_o = s_ff.bo_cnt;
  assign ovr_cnt_o    = s_ff.ovr_cnt;
  assign run_o        = s_ff.run;
  assign cmd_o        = s_ff.cmd;
  assign module_rst_o = s_ff.mod_rst;
endmodule : cipa_io_assembly
`default_nettype wire

// file: tb/cipa_io_props.sv
// cipa_io_props: port checks of the assembly image.
// assumes one clock, sync active-low reset.
`timescale 1ns/1ps
`default_nettype none
module cipa_io_props (
  input wire logic ref_clk_i, resetn_i, in_rd_i, conn_req_i, conn_ok_o,
  input wire logic conn_bad_o, ucmm_start_i, ucmm_full_o, refuse_o, run_o,
  input wire logic module_rst_o,
  input wire logic [8:0] in_tbl_len_i, in_addr_i, conn_t2o_sz_i,
  input wire logic [7:0] in_rdata_o, conn_t2o_pt_i,
  input wire logic [6:0] fault_set_i, fault_o,
  input wire logic [15:0] err_cnt_o,
  input wire logic [31:0] cmd_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  // status byte 0 bits
  property p_st0;
    in_rd_i && in_addr_i == 9'h000 |=> in_rdata_o[7:3] == 5'h00 &&
      in_rdata_o[0] == $past(run_o) && in_rdata_o[2] == |$past(fault_o);
  endproperty
  a_st0: assert property (p_st0) else $error("status");
  // pad past table
  property p_pad;
    in_rd_i && {1'b0, in_addr_i} >= {1'b0, in_tbl_len_i} + 10'h004
      |=> in_rdata_o == 8'h00;
  endproperty
  a_pad: assert property (p_pad) else $error("pad");
  property p_run; run_o |-> cmd_o[0]; endproperty
  a_run: assert property (p_run) else $error("run");
  // one pulse on a fresh bit
  property p_mrst; module_rst_o |-> $rose(cmd_o[4]) ##1 !module_rst_o; endproperty
  a_mrst: assert property (p_mrst) else $error("mrst");
  // set wins over clear
  property p_clr;
    $rose(cmd_o[1]) |-> fault_o == $past(fault_set_i) && err_cnt_o <= 16'h0001;
  endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_conn; conn_req_i |=> conn_ok_o != conn_bad_o; endproperty
  a_conn: assert property (p_conn) else $error("open");
  property p_stsz;
    conn_req_i && conn_t2o_pt_i == 8'h65 && conn_t2o_sz_i != 9'h00c |=> conn_bad_o;
  endproperty
  a_stsz: assert property (p_stsz) else $error("stsz");
  property p_ref; ucmm_full_o && ucmm_start_i |=> refuse_o; endproperty
  a_ref: assert property (p_ref) else $error("refuse");
  c_run: cover property ($rose(run_o));
  c_mrst: cover property (module_rst_o);
  c_ref: cover property (refuse_o);
endmodule : cipa_io_props
bind cipa_io_assembly cipa_io_props cipa_io_props_i (.*);
`default_nettype wire

// file: tb/cipa_scanner_model.sv
// cipa_scanner_model: scanner writing output connection frames.
// assumes the bench calls frame() and shares ref_clk_i with the block.
`timescale 1ns/1ps
`default_nettype none
module cipa_scanner_model (
  input  wire logic       ref_clk_i, // shared clock
  output logic            wr_o,      // payload byte strobe
  output logic      [8:0] addr_o,    // payload byte offset
  output logic      [7:0] wdata_o,   // payload byte
  output logic            done_o     // frame end pulse
);
  initial {wr_o, addr_o, wdata_o, done_o} = '0;
  // run/idle header, command, image
  task automatic frame(input logic [63:0] hc, input int n);
    for (int i = 0; i < n + 8; i++) begin
      @(posedge ref_clk_i);
      wr_o    <= 1'b1;
      addr_o  <= 9'(i);
      wdata_o <= (i < 8) ? hc[8*i+:8] : 8'(i) ^ 8'h5a;
    end
    @(posedge ref_clk_i);
    wr_o    <= 1'b0;
    wdata_o <= ~wdata_o; // no stale byte after release
    done_o  <= 1'b1;
    @(posedge ref_clk_i);
    done_o  <= 1'b0;
  endtask : frame
endmodule : cipa_scanner_model
`default_nettype wire

// file: tb/tb_cipa_io_assembly.sv
// tb_cipa_io_assembly: self-checking bench of the i/o assembly image.
// assumes the scanner model writes frames.
`timescale 1ns/1ps
`default_nettype none
module tb_cipa_io_assembly;
  logic        ref_clk_i = 1'b0, resetn_i, in_rd_i, out_wr_i, out_done_i;
  logic        conn_req_i, ucmm_start_i, ucmm_done_i, cls3_open_i;
  logic        cls3_close_i, req_valid_i, req_first_i, fb_rx_wr_i;
  logic        fb_tx_rd_i, online_i, err_evt_i, busoff_evt_i, ovr_evt_i;
  logic        in_rvalid_o, conn_ok_o, conn_bad_o, ucmm_full_o, refuse_o;
  logic        cls3_full_o, expl_hit_o, expl_miss_o, run_o, module_rst_o;
  logic  [8:0] in_tbl_len_i, out_tbl_len_i, in_addr_i, out_addr_i;
  logic  [8:0] conn_o2t_sz_i, conn_t2o_sz_i, fb_rx_addr_i, fb_tx_addr_i;
  logic  [7:0] out_wdata_i, conn_o2t_pt_i, conn_t2o_pt_i, req_byte_i;
  logic  [7:0] fb_rx_data_i, in_rdata_o, expl_svc_o, expl_attr_o;
  logic  [7:0] fb_tx_data_o, img [512]; // expected rx image
  logic  [6:0] fault_set_i, fault_o;
  logic [15:0] err_cnt_o, busoff_cnt_o, ovr_cnt_o, lf = 16'h5203;
  logic [31:0] cmd_o;
  int          bad_count, num_checks, cyc, len;
  cipa_io_assembly cipa_io_assembly_i (.*);
  cipa_scanner_model cipa_scanner_model_i (.ref_clk_i(ref_clk_i),
    .wr_o(out_wr_i), .addr_o(out_addr_i), .wdata_o(out_wdata_i),
    .done_o(out_done_i));
  always #4 ref_clk_i = ~ref_clk_i; // 125 MHz
  // hang guard, run needs ~4k cycles
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt
  function automatic logic ok_exp(input logic [7:0] t, o, input logic [8:0] ts, os);
    return ((t == 8'h64 && ts >= 9'h004 && ts <= 9'h1f4) ||
            (t == 8'h65 && ts == 9'h00c)) &&
           ((o == 8'h96 && os >= 9'h008 && os <= 9'h1f4) ||
            (o[7:1] == 7'h63 && os == 9'h000));
  endfunction : ok_exp
  task automatic chk(input string n, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // one read of input assembly or transmit image
  task automatic rd(input logic tx, input logic [8:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    {in_rd_i, fb_tx_rd_i, in_addr_i, fb_tx_addr_i} <= {!tx, tx, a, a};
    @(posedge ref_clk_i);
    {in_rd_i, fb_tx_rd_i} <= 2'b00;
    #1 chk("rdata", e, tx ? fb_tx_data_o : in_rdata_o);
    chk("rvalid", !tx, in_rvalid_o);
  endtask : rd
  task automatic fr(input logic ri, input logic [31:0] c, input int n);
    cipa_scanner_model_i.frame({c, 31'h0, ri}, n);
    #1 chk("cmd", c, cmd_o);
    chk("run", ri & c[0], run_o);
  endtask : fr
  task automatic ev(input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      {err_evt_i, busoff_evt_i, ovr_evt_i} <= 3'b111;
      @(posedge ref_clk_i);
      {err_evt_i, busoff_evt_i, ovr_evt_i} <= 3'b000;
    end
  endtask : ev
  task automatic cn(input logic [7:0] t, input logic [8:0] ts, input logic [7:0] o,
                    input logic [8:0] os);
    @(posedge ref_clk_i);
    {conn_req_i, conn_t2o_pt_i, conn_t2o_sz_i, conn_o2t_pt_i, conn_o2t_sz_i} <=
      {1'b1, t, ts, o, os};
    @(posedge ref_clk_i);
    conn_req_i <= 1'b0;
    #1 chk("conn", ok_exp(t, o, ts, os) ? 2'b10 : 2'b01, {conn_ok_o, conn_bad_o});
  endtask : cn
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  initial begin
    {resetn_i, in_rd_i, conn_req_i, ucmm_start_i, ucmm_done_i, cls3_open_i,
     cls3_close_i, req_valid_i, req_first_i, req_byte_i, fb_rx_wr_i, fb_tx_rd_i,
     online_i, err_evt_i, busoff_evt_i, ovr_evt_i, fault_set_i, in_tbl_len_i,
     out_tbl_len_i, in_addr_i, fb_rx_addr_i, fb_tx_addr_i, conn_o2t_pt_i,
     conn_o2t_sz_i, conn_t2o_pt_i, conn_t2o_sz_i, fb_rx_data_i} = '0;
    repeat (12) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    // random length, then all 496 bytes
    for (int j = 0; j < 2; j++) begin
      len = j ? 496 : lf[7:0];
      in_tbl_len_i <= 9'(len);
      for (int k = 0; k < 512; k++) begin
        @(posedge ref_clk_i);
        lf = nxt(lf);
        {fb_rx_wr_i, fb_rx_addr_i, fb_rx_data_i} <= {1'b1, 9'(k), lf[7:0]};
        img[k] = (k < len) ? lf[7:0] : 8'h00;
      end
      @(posedge ref_clk_i);
      fb_rx_wr_i <= 1'b0;
      for (int a = 4; a < 512; a++) rd(0, 9'(a), a < 500 ? img[a-4] : 8'h00);
    end
    online_i <= 1'b1;
    fault_set_i <= 7'h05;
    ev(3);
    fault_set_i <= 7'h00;
    fr(1, 32'h1, 0);
    rd(0, 9'h000, 8'h07);
    rd(0, 9'h003, 8'h00);
    chk("err", 16'h0003, err_cnt_o);
    fr(0, 32'h3, 0);
    chk("cnt", 32'h0, {fault_o, err_cnt_o});
    chk("cnt", 32'h0, {busoff_cnt_o, ovr_cnt_o});
    rd(0, 9'h000, 8'h02);
    ev(2);
    fr(1, 32'h3, 0);
    chk("held", 16'h0002, err_cnt_o);
    fr(1, 32'h11, 0);
    chk("mrst", 1'b1, module_rst_o);
    fr(1, 32'h11, 0);
    chk("mrst", 1'b0, module_rst_o);
    fr(1, 32'hffff_ffed, 0);
    chk("mrst", 1'b0, module_rst_o);
    for (int i = 0; i < 4; i++) fr(i[1], {31'h0, i[0]}, 0);
    lf = nxt(lf);
    len = lf[7:0];
    out_tbl_len_i <= 9'(len);
    fr(1, 32'h1, len + 4);
    for (int k = 0; k < len + 4; k++) rd(1, 9'(k), k < len ? 8'(k + 8) ^ 8'h5a : 8'h00);
    cn(8'h65, 9'h00c, 8'hc6, 9'h000);
    cn(8'h64, 9'h1f4, 8'h96, 9'h1f5);
    for (int i = 0; i < 40; i++) begin
      lf = nxt(lf);
      cn(lf[0] ? 8'h64 : 8'h65, lf[9:1], lf[10] ? 8'h96 : {7'h63, lf[11]},
         lf[12] ? 9'(lf[15:13]) : lf[8:0]);
    end
    repeat (64) @(posedge ref_clk_i) ucmm_start_i <= 1'b1;
    @(posedge ref_clk_i) ucmm_start_i <= 1'b0;
    #1 chk("full", 1'b1, ucmm_full_o);
    @(posedge ref_clk_i) ucmm_start_i <= 1'b1;
    @(posedge ref_clk_i) ucmm_start_i <= 1'b0;
    #1 chk("refuse", 1'b1, refuse_o);
    end_sim();
  end
endmodule : tb_cipa_io_assembly
`default_nettype wire
